// *** design/i2c_slave_transmit.sv ***
// Slave read path of a two-wire serial port: address, stretch, shift out.
// Notes on behaviour
// - Matching read address sets read status, buffers address, acknowledges.
// - After read-address acknowledge, clear clock release and hold SCL low.
// - Writing the data buffer also loads the transmit shift register.
// - Setting clock release frees SCL so the master may clock again.
// - Eight data bits change on falling SCL, stable while SCL high.
// - Master acknowledge latched on ninth rising SCL edge into status.
// - A latched not-acknowledge ends the transfer; device waits for start.
// - On not-acknowledge, no stretch, but the interrupt flag still sets.
// - On acknowledge, stretch SCL until release set, whether or not next byte loaded.
// - Interrupt flag rises once per byte on the ninth falling SCL edge.
// - Collision while shifting with detection enabled: flag it, go idle.
// - Start sets start-seen; interrupt flag only if start interrupts enabled.
// - Reading the received address from the buffer clears buffer full.
// - Repeated start or stop leaves the device no longer addressed.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_transmit
  import i2c_tx_pkg::*;
#(
  parameter logic [ADDR_BITS-1:0] OWN_ADDR = 7'h2a
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Bus pins, open drain: enable high pulls the line low.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Software side.
  input wire sw_ctrl_type ctrl_i,
  output logic [BYTE_BITS-1:0] serial_data_buffer_o,
  output status_type status_o
);
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det, collision;
  state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [BYTE_BITS-1:0] buf_q, buf_d, sr_q, sr_d;
  status_type st_q, st_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d, pin_low_q;

  pin_filter #(.RESET_VAL(PIN_IDLE)) u_scl (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pin_i(scl_i), .level_o(scl_s)
  );
  pin_filter #(.RESET_VAL(PIN_IDLE)) u_sda (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pin_i(sda_i), .level_o(sda_s)
  );

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  // A released one read back as zero means another driver won the line.
  assign collision = (state_q == ST_TX) && scl_rise && sr_q[BYTE_BITS-1]
                     && !sda_s && ctrl_i.slave_collision_detect_enable;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    buf_d = buf_q;
    sr_d = sr_q;
    st_d = st_q;
    if (ctrl_i.irq_clear) st_d.serial_irq_flag = 1'b0;
    if (ctrl_i.collision_clear) st_d.bus_collision_flag = 1'b0;
    if (ctrl_i.buf_read) st_d.buffer_full_flag = 1'b0;
    if (ctrl_i.release_set) st_d.clock_release_bit = 1'b1;
    if (ctrl_i.buf_write) begin
      buf_d = ctrl_i.buf_wdata;
      sr_d = ctrl_i.buf_wdata;
    end
    // Hardware sets below come after the clears, so a set wins.
    if (start_det) begin
      state_d = ST_ADDR;
      cnt_d = BIT_CNT_RESET;
      st_d.start_seen = 1'b1;
      st_d.addressed = 1'b0;
      if (ctrl_i.start_irq_en) st_d.serial_irq_flag = 1'b1;
    end else if (stop_det) begin
      state_d = ST_IDLE;
      st_d.addressed = 1'b0;
      st_d.start_seen = 1'b0;
    end else if (collision) begin
      state_d = ST_IDLE;
      st_d.addressed = 1'b0;
      st_d.bus_collision_flag = 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: ;
        ST_ADDR: begin
          if (scl_rise && cnt_q != ADDR_DONE) begin
            buf_d = {buf_q[BYTE_BITS-2:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == ADDR_DONE) begin
            // Only reads are served here; anything else is left alone.
            if (buf_q[BYTE_BITS-1:1] == OWN_ADDR && buf_q[0]) begin
              state_d = ST_ADDR_ACK;
              st_d.read_status = 1'b1;
              st_d.buffer_full_flag = 1'b1;
              st_d.addressed = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            state_d = ST_TX;
            cnt_d = BIT_CNT_RESET;
            st_d.clock_release_bit = 1'b0;
            st_d.serial_irq_flag = 1'b1;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            sr_d = {sr_q[BYTE_BITS-2:0], 1'b0};
            if (cnt_q == LAST_BIT) state_d = ST_MACK;
            else cnt_d = cnt_q + 4'h1;
          end
        end
        ST_MACK: begin
          if (scl_rise) st_d.master_ack_status = sda_s;
          if (scl_fall) begin
            st_d.serial_irq_flag = 1'b1;
            cnt_d = BIT_CNT_RESET;
            if (st_q.master_ack_status) begin
              state_d = ST_IDLE;
              st_d.addressed = 1'b0;
              st_d.read_status = 1'b0;
            end else begin
              state_d = ST_TX;
              st_d.clock_release_bit = 1'b0;
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
    // The master is expected to wait while SCL is held.
    scl_oe_d = (state_d == ST_TX) && !st_d.clock_release_bit;
    sda_oe_d = (state_d == ST_ADDR_ACK)
               || ((state_d == ST_TX) && !sr_d[BYTE_BITS-1]);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= BIT_CNT_RESET;
      buf_q <= BYTE_RESET;
      sr_q <= BYTE_RESET;
      st_q <= '0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      pin_low_q <= 1'b0;
      scl_p_q <= PIN_IDLE;
      sda_p_q <= PIN_IDLE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      buf_q <= buf_d;
      sr_q <= sr_d;
      st_q <= st_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      pin_low_q <= 1'b0;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_o = pin_low_q;
  assign sda_o = pin_low_q;
  assign scl_oe_o = scl_oe_q;
  assign sda_oe_o = sda_oe_q;
  assign serial_data_buffer_o = buf_q;
  assign status_o = st_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence addr_match_s;
    state_q == ST_ADDR && scl_fall && cnt_q == ADDR_DONE && !start_det
      && !stop_det && buf_q[BYTE_BITS-1:1] == OWN_ADDR && buf_q[0];
  endsequence
  sequence ack_then_stretch_s;
    st_q.read_status && sda_oe_o && st_q.buffer_full_flag;
  endsequence

  addr_ack_drive_a: assert property (
    addr_match_s |=> ack_then_stretch_s)
    else $error("read address not acknowledged");
  hold_after_ack_a: assert property (
    state_q == ST_ADDR_ACK && scl_fall && !start_det && !stop_det
    |=> scl_oe_o && !st_q.clock_release_bit)
    else $error("SCL not held after address acknowledge");
  load_shift_a: assert property (
    ctrl_i.buf_write && !(state_q == ST_TX && scl_fall)
    |=> sr_q == $past(ctrl_i.buf_wdata))
    else $error("shift register not loaded by buffer write");
  release_scl_a: assert property (
    state_q == ST_TX && ctrl_i.release_set && !scl_fall && !start_det
    && !stop_det |=> !scl_oe_o)
    else $error("SCL still held after release");
  ack_latch_a: assert property (
    state_q == ST_MACK && scl_rise && !start_det && !stop_det
    |=> st_q.master_ack_status == $past(sda_s))
    else $error("master acknowledge not latched");
  nack_idle_a: assert property (
    state_q == ST_MACK && scl_fall && st_q.master_ack_status
    && !start_det && !stop_det
    |=> state_q == ST_IDLE && !scl_oe_o && st_q.serial_irq_flag)
    else $error("not-acknowledge did not end transfer");
  byte_irq_a: assert property (
    state_q == ST_MACK && scl_fall && !st_q.master_ack_status
    && !start_det && !stop_det
    |=> st_q.serial_irq_flag && scl_oe_o)
    else $error("byte interrupt or stretch missing");
  collision_a: assert property (
    collision && !start_det && !stop_det
    |=> st_q.bus_collision_flag && state_q == ST_IDLE)
    else $error("collision not handled");
  start_seen_a: assert property (
    start_det
    |=> st_q.start_seen && !st_q.addressed
    && (st_q.serial_irq_flag || !$past(ctrl_i.start_irq_en)))
    else $error("start condition not recorded");
  // An address load in the same cycle wins over the read, so skip it.
  bf_clear_a: assert property (
    ctrl_i.buf_read
    && !(state_q == ST_ADDR && scl_fall && cnt_q == ADDR_DONE)
    |=> !st_q.buffer_full_flag)
    else $error("buffer full not cleared by read");
endmodule : i2c_slave_transmit
`default_nettype wire

// *** design/i2c_tx_pkg.sv ***
// Shared constants and types for the two-wire slave transmit path.
package i2c_tx_pkg;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned ADDR_BITS = 7;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ADDR_DONE = 4'h8;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } state_type;

  // Software-side strobes and settings, all on the system clock.
  typedef struct packed {
    logic buf_write;
    logic [7:0] buf_wdata;
    logic buf_read;
    logic release_set;
    logic irq_clear;
    logic collision_clear;
    logic start_irq_en;
    logic slave_collision_detect_enable;
  } sw_ctrl_type;

  // Status bits seen by software.
  typedef struct packed {
    logic read_status;
    logic buffer_full_flag;
    logic clock_release_bit;
    logic master_ack_status;
    logic serial_irq_flag;
    logic start_seen;
    logic bus_collision_flag;
    logic addressed;
  } status_type;
endpackage : i2c_tx_pkg

// *** design/pin_filter.sv ***
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q, s2_q, s3_q, level_q, level_d;

  // A new level counts only once stages two and three agree.
  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;
endmodule : pin_filter
`default_nettype wire

// *** test/i2c_master_model.sv ***
// Behavioural two-wire bus master that addresses the slave and reads bytes.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // Resolved bus lines.
  input wire logic scl_i,
  input wire logic sda_i,
  // Open-drain pulls: high drives the line low.
  output logic scl_low_o,
  output logic sda_low_o,
  output logic stuck_o
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    stuck_o = 1'b0;
  end

  task start_cond();
    sda_low_o = 1'b1;
    #62.5 scl_low_o = 1'b1;
    #31.25;
  endtask : start_cond

  task stop_cond();
    sda_low_o = 1'b1;
    #31.25 scl_low_o = 1'b0;
    #62.5 sda_low_o = 1'b0;
    #62.5;
  endtask : stop_cond

  // The high phase is only timed once the slave has let SCL go.
  task clk_bit(input logic b, output logic r);
    int n;
    n = 0;
    sda_low_o = !b;
    #31.25 scl_low_o = 1'b0;
    while (!scl_i && n < 4000) begin
      #5 n++;
    end
    if (!scl_i) stuck_o = 1'b1;
    #31.25 r = sda_i;
    #31.25 scl_low_o = 1'b1;
    #31.25;
  endtask : clk_bit

  task xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
            output logic ak);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
    clk_bit(a, ak);
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// *** test/i2c_slave_transmit_tb.sv ***
// Testbench for the two-wire slave transmit path.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_transmit_tb;
  import i2c_tx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n;
  sw_ctrl_type ctrl;
  logic scl_oe, sda_oe, m_scl, m_sda, stuck, ak;
  logic scl_lvl, sda_lvl;
  logic [7:0] dbuf, q;
  status_type st;
  wire scl_w;
  wire sda_w;
  int errors = 0;
  int cmp_count = 0;
  // Bit 8 is the master's answer (1 = not acknowledge), low bits the byte.
  logic [8:0] rows [3] = '{9'h0a5, 9'h03c, 9'h181};

  always #2.5 ref_clk = ~ref_clk;
  assign scl_w = !(scl_oe | m_scl);
  assign sda_w = !(sda_oe | m_sda);

  i2c_slave_transmit i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .scl_i(scl_w), .scl_o(scl_lvl), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(sda_lvl), .sda_oe_o(sda_oe), .ctrl_i(ctrl),
    .serial_data_buffer_o(dbuf), .status_o(st));
  i2c_master_model i_master (.scl_i(scl_w), .sda_i(sda_w),
    .scl_low_o(m_scl), .sda_low_o(m_sda), .stuck_o(stuck));

  // Wide enough for a status pair beside the whole data buffer.
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobe bits: 0 write, 1 read, 2 release, 3 flag clear, 4 collision clear.
  task sw(input logic [4:0] k, input logic [7:0] d);
    @(negedge ref_clk);
    ctrl.buf_write = k[0];
    ctrl.buf_wdata = d;
    ctrl.buf_read = k[1];
    ctrl.release_set = k[2];
    ctrl.irq_clear = k[3];
    ctrl.collision_clear = k[4];
    @(negedge ref_clk);
    {ctrl.buf_write, ctrl.buf_read, ctrl.release_set} = 3'h0;
    {ctrl.irq_clear, ctrl.collision_clear} = 2'h0;
  endtask : sw

  task wait10();
    repeat (10) @(negedge ref_clk);
  endtask : wait10

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge stuck) begin
    errors++;
    $display("[FAIL] %0t SCL never released", $time);
    tally_and_finish();
  end

  initial begin
    ctrl = '0;
    rst_n = 1'b0;
    wait10();
    chk(st, 8'h00);
    chk({scl_oe, sda_oe}, 8'h00);
    chk({scl_lvl, sda_lvl}, 8'h00);
    rst_n = 1'b1;
    wait10();
    $display("test reset done");
    i_master.start_cond();
    wait10();
    chk(st.start_seen, 8'h01);
    chk(st.serial_irq_flag, 8'h00);
    i_master.xfer(8'h54, 1'b1, q, ak);
    chk(ak, 8'h01);
    i_master.stop_cond();
    $display("test write address done");
    i_master.start_cond();
    i_master.xfer(8'h55, 1'b1, q, ak);
    wait10();
    chk(ak, 8'h00);
    chk({st.read_status, st.buffer_full_flag, dbuf}, 10'h355);
    chk({st.clock_release_bit, scl_oe}, 8'h01);
    chk(st.serial_irq_flag, 8'h01);
    sw(5'h08, 8'h00);
    chk(st.serial_irq_flag, 8'h00);
    sw(5'h02, 8'h00);
    chk(st.buffer_full_flag, 8'h00);
    for (int i = 0; i < 3; i++) begin
      fork
        i_master.xfer(8'hff, rows[i][8], q, ak);
        begin
          repeat (40) @(negedge ref_clk);
          chk({scl_w, scl_oe}, 8'h01);
          sw(5'h01, rows[i][7:0]);
          sw(5'h04, 8'h00);
        end
      join
      wait10();
      chk(q, rows[i][7:0]);
      chk(st.master_ack_status, rows[i][8]);
      chk(st.serial_irq_flag, 8'h01);
      chk(scl_oe, !rows[i][8]);
      chk(st.addressed, !rows[i][8]);
      sw(5'h08, 8'h00);
      $display("test row %0d done", i);
    end
    i_master.stop_cond();
    wait10();
    chk({st.addressed, st.read_status}, 8'h00);
    ctrl.start_irq_en = 1'b1;
    ctrl.slave_collision_detect_enable = 1'b1;
    i_master.start_cond();
    wait10();
    chk(st.serial_irq_flag, 8'h01);
    sw(5'h08, 8'h00);
    i_master.xfer(8'h55, 1'b1, q, ak);
    wait10();
    sw(5'h01, 8'h7f);
    sw(5'h04, 8'h00);
    i_master.clk_bit(1'b1, ak);
    chk(ak, 8'h00);
    i_master.clk_bit(1'b0, ak);
    wait10();
    chk(st.bus_collision_flag, 8'h01);
    chk({st.addressed, sda_oe, scl_oe}, 8'h00);
    sw(5'h10, 8'h00);
    ctrl.slave_collision_detect_enable = 1'b0;
    chk(st.bus_collision_flag, 8'h00);
    i_master.stop_cond();
    $display("test collision done");
    i_master.start_cond();
    i_master.xfer(8'h55, 1'b1, q, ak);
    wait10();
    chk(st.addressed, 8'h01);
    sw(5'h05, 8'hff);
    chk({sda_oe, scl_oe}, 8'h00);
    i_master.stop_cond();
    wait10();
    chk({st.addressed, st.start_seen}, 8'h00);
    chk({scl_lvl, sda_lvl}, 8'h00);
    $display("test stop while addressed done");
    tally_and_finish();
  end
endmodule : i2c_slave_transmit_tb
`default_nettype wire
